/* hdl/csr_core_regs.sv */
/*
 core special-function registers: data pointer, stack top pointer,
 primary and secondary arithmetic registers, program status word.
 assumes the execution datapath drives the control inputs synchronously,
 at most one direct write and one instruction update per register per cycle.
*/
`timescale 1ns/10ps
`include "csr_defines.svh"

module csr_core_regs
  import csr_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // direct byte access
  input wire logic [7:0] DIR_ADDR,
  input wire logic DIR_WR,
  input wire logic [7:0] DIR_WDATA,
  output logic [7:0] DIR_RDATA,
  output logic DIR_HIT,
  output logic DIR_RAM_SEL,
  // bit access
  input wire logic BIT_WR,
  input wire logic [2:0] BIT_SEL,
  input wire logic BIT_VAL,
  output logic BIT_RDATA,
  // arithmetic
  input wire csr_op_e ALU_OP,
  input wire logic [7:0] ALU_OPERAND,
  // accumulator load from datapath
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_LOAD_DATA,
  // stack and pointer control
  input wire logic STACK_PUSH,
  input wire logic STACK_POP,
  input wire logic DATA_POINTER_16_INC,
  // state outputs
  output logic [15:0] DATA_POINTER_16,
  output logic [7:0] STACK_TOP_POINTER,
  output logic [7:0] STACK_WR_ADDR,
  output logic [7:0] PRIMARY_ARITH_REG,
  output logic [7:0] SECOND_ARITH_REG,
  output logic [7:0] PROGRAM_STATUS_WORD,
  output logic [4:0] BANK_BASE
);

  logic [7:0] dpl_r;
  logic [7:0] dph_r;
  logic [7:0] stack_r;
  logic [7:0] acc_r;
  logic [7:0] sec_r;
  logic [7:0] psw_r;
  logic [7:0] acc_nxt;
  logic [7:0] sec_nxt;
  logic [7:0] psw_nxt;
  logic [7:0] alu_acc;
  logic [7:0] alu_sec;
  logic alu_cy;
  logic alu_ac;
  logic alu_ov;
  logic alu_sec_wr;
  logic alu_active;
  logic [15:0] data_pointer_16_next;
  logic [7:0] bit_tgt;
  logic [1:0] bank_sel;
  logic stack_dir_wr;
  logic dpl_dir_wr;
  logic dph_dir_wr;
  logic acc_dir_wr;
  logic sec_dir_wr;
  logic psw_dir_wr;
  logic acc_bit_wr;
  logic psw_bit_wr;

  // decodes a write hit, direct or bit, on one register address
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target,
                                  input logic we);
    wr_hit = we && (a == target);
  endfunction

  // replaces one bit in a byte
  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] s,
                                         input logic b);
    logic [7:0] r;
    r = v;
    r[s] = b;
    set_bit = r;
  endfunction

  // ==========================================================
  // arithmetic unit
  csr_alu_flags u_alu (
    .op(ALU_OP),
    .acc_in(acc_r),
    .sec_in(sec_r),
    .operand(ALU_OPERAND),
    .carry_in(psw_r[`CSR_PSW_CY]),
    .acc_out(alu_acc),
    .sec_out(alu_sec),
    .cy_out(alu_cy),
    .ac_out(alu_ac),
    .ov_out(alu_ov),
    .writes_sec(alu_sec_wr)
  );

  assign alu_active = (ALU_OP != CSR_OP_NONE);

  // ==========================================================
  // write decode, one direct strobe per register, plus a bit strobe for the two bit-addressable ones
  assign stack_dir_wr = wr_hit(DIR_ADDR, `CSR_ADDR_STACK, DIR_WR);
  assign dpl_dir_wr = wr_hit(DIR_ADDR, `CSR_ADDR_DPL, DIR_WR);
  assign dph_dir_wr = wr_hit(DIR_ADDR, `CSR_ADDR_DPH, DIR_WR);
  assign acc_dir_wr = wr_hit(DIR_ADDR, `CSR_ADDR_ACC, DIR_WR);
  assign sec_dir_wr = wr_hit(DIR_ADDR, `CSR_ADDR_SEC, DIR_WR);
  assign psw_dir_wr = wr_hit(DIR_ADDR, `CSR_ADDR_PSW, DIR_WR);
  // bit writes reach only the two bit-addressable registers
  assign acc_bit_wr = wr_hit(DIR_ADDR, `CSR_ADDR_ACC, BIT_WR);
  assign psw_bit_wr = wr_hit(DIR_ADDR, `CSR_ADDR_PSW, BIT_WR);

  // ==========================================================
  // data pointer
  // low byte carry ripples into the high byte
  assign data_pointer_16_next = {dph_r, dpl_r} + `CSR_DATA_POINTER_16_STEP;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dpl_r <= `CSR_RST_ZERO;
    end else if (dpl_dir_wr) begin
      dpl_r <= DIR_WDATA;
    end else if (DATA_POINTER_16_INC) begin
      dpl_r <= data_pointer_16_next[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dph_r <= `CSR_RST_ZERO;
    end else if (dph_dir_wr) begin
      dph_r <= DIR_WDATA;
    end else if (DATA_POINTER_16_INC) begin
      dph_r <= data_pointer_16_next[15:8];
    end
  end

  assign DATA_POINTER_16 = {dph_r, dpl_r};

  // ==========================================================
  // stack top pointer
  // pre-increment stack
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stack_r <= `CSR_RST_STACK;
    end else if (stack_dir_wr) begin
      stack_r <= DIR_WDATA;
    end else if (STACK_PUSH) begin
      stack_r <= stack_r + `CSR_STACK_STEP;
    end else if (STACK_POP) begin
      stack_r <= stack_r - `CSR_STACK_STEP;
    end
  end

  assign STACK_WR_ADDR = stack_r + `CSR_STACK_STEP;

  // ==========================================================
  // bit-addressable target selection
  // bit access decode
  always_comb begin
    unique case (DIR_ADDR)
      `CSR_ADDR_ACC: bit_tgt = acc_r;
      `CSR_ADDR_PSW: bit_tgt = psw_r;
      default: bit_tgt = `CSR_RST_ZERO;
    endcase
  end
  assign BIT_RDATA = bit_tgt[BIT_SEL];

  // ==========================================================
  // primary and secondary arithmetic registers
  // accumulator next value
  // priority: direct write, bit write, datapath load, arithmetic
  always_comb begin
    acc_nxt = acc_r;
    if (acc_dir_wr) begin
      acc_nxt = DIR_WDATA;
    end else if (acc_bit_wr) begin
      acc_nxt = set_bit(acc_r, BIT_SEL, BIT_VAL);
    end else if (ACC_LOAD) begin
      acc_nxt = ACC_LOAD_DATA;
    end else if (alu_active) begin
      acc_nxt = alu_acc;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_r <= `CSR_RST_ZERO;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  always_comb begin
    sec_nxt = sec_r;
    if (sec_dir_wr) begin
      sec_nxt = DIR_WDATA;
    end else if (alu_sec_wr) begin
      sec_nxt = alu_sec;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sec_r <= `CSR_RST_ZERO;
    end else begin
      sec_r <= sec_nxt;
    end
  end

  // ==========================================================
  // program status word
  always_comb begin
    psw_nxt = psw_r;
    // a software write in the same cycle drops the arithmetic flags
    if (psw_dir_wr) begin
      psw_nxt = DIR_WDATA;
    end else if (psw_bit_wr) begin
      psw_nxt = set_bit(psw_r, BIT_SEL, BIT_VAL);
    end else if (alu_active) begin
      psw_nxt[`CSR_PSW_CY] = alu_cy;
      psw_nxt[`CSR_PSW_AC] = alu_ac;
      psw_nxt[`CSR_PSW_OV] = alu_ov;
    end
    psw_nxt[`CSR_PSW_PAR] = ^acc_nxt;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      psw_r <= `CSR_RST_ZERO;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  assign bank_sel = psw_r[`CSR_PSW_RS_HI:`CSR_PSW_RS_LO];
  assign BANK_BASE = {bank_sel, 3'h0};

  // ==========================================================
  // direct read mux and space decode
  // function register space
  always_comb begin
    DIR_HIT = 1'b1;
    unique case (DIR_ADDR)
      `CSR_ADDR_STACK: DIR_RDATA = stack_r;
      `CSR_ADDR_DPL: DIR_RDATA = dpl_r;
      `CSR_ADDR_DPH: DIR_RDATA = dph_r;
      `CSR_ADDR_PSW: DIR_RDATA = psw_r;
      `CSR_ADDR_ACC: DIR_RDATA = acc_r;
      `CSR_ADDR_SEC: DIR_RDATA = sec_r;
      default: begin
        DIR_RDATA = `CSR_RST_ZERO;
        DIR_HIT = 1'b0;
      end
    endcase
  end
  assign DIR_RAM_SEL = !DIR_ADDR[`CSR_SFR_SPACE_BIT];

  // register state outputs
  assign STACK_TOP_POINTER = stack_r;
  assign PRIMARY_ARITH_REG = acc_r;
  assign SECOND_ARITH_REG = sec_r;
  assign PROGRAM_STATUS_WORD = psw_r;

endmodule

/* hdl/csr_defines.svh */
/*
 core special-function register constants: direct addresses, reset values,
 status word bit positions and bank geometry.
 assumes inclusion by bare name from design files.
*/
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// ==========================================================
// direct addresses
`define CSR_ADDR_STACK 8'h81
`define CSR_ADDR_DPL 8'h82
`define CSR_ADDR_DPH 8'h83
`define CSR_ADDR_PSW 8'hD0
`define CSR_ADDR_ACC 8'hE0
`define CSR_ADDR_SEC 8'hF0
`define CSR_SFR_SPACE_BIT 7

// ==========================================================
// reset values
`define CSR_RST_STACK 8'h07
`define CSR_RST_ZERO 8'h00

// ==========================================================
// status word bits
`define CSR_PSW_CY 7
`define CSR_PSW_AC 6
`define CSR_PSW_F0 5
`define CSR_PSW_RS_HI 4
`define CSR_PSW_RS_LO 3
`define CSR_PSW_OV 2
`define CSR_PSW_F1 1
`define CSR_PSW_PAR 0

// ==========================================================
// arithmetic constants
`define CSR_BANK_SHIFT 3
`define CSR_BYTE_MAX 16'h00FF
`define CSR_STACK_STEP 8'h01
`define CSR_DATA_POINTER_16_STEP 16'h0001

`endif

/* hdl/csr_pkg.sv */
/*
 types shared by the core register block.
 assumes nothing of its surroundings.
*/
package csr_pkg;
  // ==========================================================
  // arithmetic operation codes from the execution datapath
  typedef enum logic [2:0] {
    CSR_OP_NONE = 3'b000,
    CSR_OP_ADD  = 3'b001,
    CSR_OP_ADDC = 3'b010,
    CSR_OP_SUBB = 3'b011,
    CSR_OP_MUL  = 3'b100,
    CSR_OP_DIV  = 3'b101
  } csr_op_e;
endpackage

/* hdl/csr_alu_flags.sv */
/*
 combinational arithmetic unit: computes accumulator result, secondary
 result and carry, nibble-carry and overflow flags for one operation.
 assumes operands are stable for the cycle in which op is applied.
*/
`timescale 1ns/10ps
`include "csr_defines.svh"

module csr_alu_flags
  import csr_pkg::*;
(
  // operation
  input wire csr_op_e op,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] sec_in,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  // results
  output logic [7:0] acc_out,
  output logic [7:0] sec_out,
  output logic cy_out,
  output logic ac_out,
  output logic ov_out,
  output logic writes_sec
);

  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [15:0] prod;
  logic ci;

  // arithmetic and flag computation per operation
  always_comb begin
    ci = (op == CSR_OP_ADDC || op == CSR_OP_SUBB) ? carry_in : 1'b0;
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'h0000;
    acc_out = acc_in;
    sec_out = sec_in;
    cy_out = 1'b0;
    ac_out = 1'b0;
    ov_out = 1'b0;
    writes_sec = 1'b0;
    unique case (op)
      CSR_OP_ADD, CSR_OP_ADDC: begin
        sum9 = {1'b0, acc_in} + {1'b0, operand} + {8'h00, ci};
        nib5 = {1'b0, acc_in[3:0]} + {1'b0, operand[3:0]} + {4'h0, ci};
        acc_out = sum9[7:0];
        cy_out = sum9[8];
        ac_out = nib5[4];
        // signed overflow: like signs in, other sign out
        ov_out = (acc_in[7] == operand[7]) && (sum9[7] != acc_in[7]);
      end
      CSR_OP_SUBB: begin
        sum9 = {1'b0, acc_in} - {1'b0, operand} - {8'h00, ci};
        nib5 = {1'b0, acc_in[3:0]} - {1'b0, operand[3:0]} - {4'h0, ci};
        acc_out = sum9[7:0];
        cy_out = sum9[8];
        ac_out = nib5[4];
        ov_out = (acc_in[7] != operand[7]) && (sum9[7] != acc_in[7]);
      end
      CSR_OP_MUL: begin
        // carry and nibble carry stay at their cleared defaults
        prod = {8'h00, acc_in} * {8'h00, sec_in};
        acc_out = prod[7:0];
        sec_out = prod[15:8];
        writes_sec = 1'b1;
        ov_out = (prod > `CSR_BYTE_MAX);
      end
      CSR_OP_DIV: begin
        writes_sec = 1'b1;
        if (sec_in == `CSR_RST_ZERO) begin
          ov_out = 1'b1;
        end else begin
          acc_out = acc_in / sec_in;
          sec_out = acc_in % sec_in;
        end
      end
      default: begin
      end
    endcase
  end

endmodule

/* verification/csr_core_regs_monitor.sv */
/*
 checker for the core registers: relations between ports.
 assumes binding to csr_core_regs, one clock domain.
*/
`timescale 1ns/10ps
module csr_core_regs_monitor
  import csr_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // requests
  input wire logic [7:0] DIR_ADDR,
  input wire logic DIR_WR,
  input wire logic [7:0] DIR_WDATA,
  input wire logic BIT_WR,
  input wire csr_op_e ALU_OP,
  input wire logic ACC_LOAD,
  input wire logic STACK_PUSH,
  input wire logic DATA_POINTER_16_INC,
  // state
  input wire logic DIR_RAM_SEL,
  input wire logic [15:0] DATA_POINTER_16,
  input wire logic [7:0] STACK_TOP_POINTER,
  input wire logic [7:0] STACK_WR_ADDR,
  input wire logic [7:0] PRIMARY_ARITH_REG,
  input wire logic [7:0] SECOND_ARITH_REG,
  input wire logic [7:0] PROGRAM_STATUS_WORD,
  input wire logic [4:0] BANK_BASE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  logic quiet;
  // no software write competes with the datapath
  assign quiet = !DIR_WR && !BIT_WR && !ACC_LOAD;
  // ==========================================================
  // assertions
  a_push_incr: assert property (
    STACK_PUSH && !DIR_WR |=> STACK_TOP_POINTER == $past(STACK_TOP_POINTER) + 8'h01)
    else $error("stack pointer not incremented");
  a_push_addr: assert property (
    STACK_WR_ADDR == STACK_TOP_POINTER + 8'h01) else $error("push address wrong");
  a_parity_track: assert property (
    PROGRAM_STATUS_WORD[0] == ^PRIMARY_ARITH_REG) else $error("parity wrong");
  a_bank_decode: assert property (
    BANK_BASE == {PROGRAM_STATUS_WORD[4:3], 3'h0}) else $error("bank base wrong");
  a_ram_space: assert property (
    DIR_RAM_SEL == !DIR_ADDR[7]) else $error("ram select wrong");
  a_ptr_incr: assert property (
    DATA_POINTER_16_INC && !DIR_WR |=> DATA_POINTER_16 == $past(DATA_POINTER_16) + 16'h0001)
    else $error("pointer not incremented");
  a_low_byte: assert property (
    DIR_WR && DIR_ADDR == 8'h82 |=> DATA_POINTER_16[7:0] == $past(DIR_WDATA))
    else $error("pointer low byte not written");
  a_user_flags: assert property (
    !BIT_WR && !(DIR_WR && DIR_ADDR == 8'hD0) |=>
    $stable({PROGRAM_STATUS_WORD[5], PROGRAM_STATUS_WORD[1]})) else $error("user flag moved");
  a_mul_range: assert property (
    ALU_OP == CSR_OP_MUL && quiet |=> PROGRAM_STATUS_WORD[2] ==
    ($past(PRIMARY_ARITH_REG) * $past(SECOND_ARITH_REG) > 16'h00FF)) else $error("mul range");
  a_div_zero: assert property (
    ALU_OP == CSR_OP_DIV && SECOND_ARITH_REG == 8'h00 && quiet |=>
    PROGRAM_STATUS_WORD[2] && $stable(PRIMARY_ARITH_REG)) else $error("div by zero");
  a_muldiv_carry: assert property (
    (ALU_OP == CSR_OP_MUL || ALU_OP == CSR_OP_DIV) && quiet |=>
    !PROGRAM_STATUS_WORD[7] && !PROGRAM_STATUS_WORD[6]) else $error("carries not cleared");
  // main scenarios
  c_push: cover property (STACK_PUSH);
  c_mul: cover property (ALU_OP == CSR_OP_MUL && quiet);
  c_div_zero: cover property (ALU_OP == CSR_OP_DIV && SECOND_ARITH_REG == 8'h00);
endmodule

bind csr_core_regs csr_core_regs_monitor csr_core_regs_monitor_inst (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .DIR_ADDR(DIR_ADDR), .DIR_WR(DIR_WR),
  .DIR_WDATA(DIR_WDATA), .BIT_WR(BIT_WR), .ALU_OP(ALU_OP), .ACC_LOAD(ACC_LOAD),
  .STACK_PUSH(STACK_PUSH), .DATA_POINTER_16_INC(DATA_POINTER_16_INC), .DIR_RAM_SEL(DIR_RAM_SEL),
  .DATA_POINTER_16(DATA_POINTER_16), .STACK_TOP_POINTER(STACK_TOP_POINTER),
  .STACK_WR_ADDR(STACK_WR_ADDR), .PRIMARY_ARITH_REG(PRIMARY_ARITH_REG),
  .SECOND_ARITH_REG(SECOND_ARITH_REG), .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD),
  .BANK_BASE(BANK_BASE));

/* verification/csr_stack_ram_model.sv */
/*
 stack memory of the datapath: stores pushed bytes, shows the top byte.
 assumes push strobes from the bench, addresses from the register block.
*/
`timescale 1ns/10ps
module csr_stack_ram_model (
  // clock
  input wire logic clk,
  // stack traffic
  input wire logic push,
  input wire logic [7:0] push_addr,
  input wire logic [7:0] push_byte,
  input wire logic [7:0] top,
  output logic [7:0] top_byte
);
  logic [7:0] mem_r [256];
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[push_addr] <= push_byte;
    end
  end
  // byte a pop would return
  assign top_byte = mem_r[top];
endmodule

/* verification/testbench.sv */
/*
 self-checking bench for csr_core_regs with a stack memory model.
 assumes 40 MHz clock, active-low asynchronous reset.
*/
`timescale 1ns/10ps
module testbench;
  import csr_pkg::*;
  logic clk, rstn, wr, hit, ramsel, bwr, bval, brd, ld, push, pop, dinc, c;
  logic [7:0] addr, wdata, rdata, opnd, lddata, stk, stkw, pri, sec, stat, pbyte, top, v, a, x, s;
  logic [2:0] bsel;
  logic [15:0] dp16;
  logic [4:0] bank, keep;
  logic [18:0] e;
  logic [31:0] seed;
  csr_op_e op;
  int n_errors, checked;
  logic [7:0] regs [5] = '{8'h81, 8'h82, 8'h83, 8'hE0, 8'hF0};
  logic [7:0] got [5];
  csr_op_e ops [5] = '{CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB, CSR_OP_MUL, CSR_OP_DIV};
  csr_core_regs csr_core_regs_inst (.CORE_CLK(clk), .RESETN(rstn), .DIR_ADDR(addr),
    .DIR_WR(wr), .DIR_WDATA(wdata), .DIR_RDATA(rdata), .DIR_HIT(hit), .DIR_RAM_SEL(ramsel),
    .BIT_WR(bwr), .BIT_SEL(bsel), .BIT_VAL(bval), .BIT_RDATA(brd), .ALU_OP(op),
    .ALU_OPERAND(opnd), .ACC_LOAD(ld), .ACC_LOAD_DATA(lddata), .STACK_PUSH(push),
    .STACK_POP(pop), .DATA_POINTER_16_INC(dinc), .DATA_POINTER_16(dp16), .STACK_TOP_POINTER(stk),
    .STACK_WR_ADDR(stkw), .PRIMARY_ARITH_REG(pri), .SECOND_ARITH_REG(sec),
    .PROGRAM_STATUS_WORD(stat), .BANK_BASE(bank));
  csr_stack_ram_model csr_stack_ram_model_inst (.clk(clk), .push(push), .push_addr(stkw),
    .push_byte(pbyte), .top(stk), .top_byte(top));
  // clock, 25 ns period
  always #12.5 clk = ~clk;
  // ==========================================================
  // helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // expected {second, carry, nibble, range, primary}; mul/div clear both carries
  function automatic logic [18:0] want(csr_op_e o, logic [7:0] a, x, s, logic c);
    logic [8:0] r;
    logic [4:0] n;
    logic [15:0] p;
    logic k;
    k = (o == CSR_OP_ADDC || o == CSR_OP_SUBB) ? c : 1'h0;
    p = a * s;
    if (o == CSR_OP_MUL) return {p[15:8], 2'h0, p > 16'h00FF, p[7:0]};
    if (o == CSR_OP_DIV) return (s == 8'h00) ? {s, 2'h0, 1'h1, a} : {a % s, 2'h0, 1'h0, a / s};
    if (o == CSR_OP_SUBB) begin
      r = {1'h0, a} - x - k;
      n = {1'h0, a[3:0]} - x[3:0] - k;
      return {s, r[8], n[4], (a[7] != x[7]) && (r[7] != a[7]), r[7:0]};
    end
    r = a + x + k;
    n = a[3:0] + x[3:0] + k;
    return {s, r[8], n[4], (a[7] == x[7]) && (r[7] != a[7]), r[7:0]};
  endfunction
  task chk(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ends a one-cycle request and lets outputs settle
  task tick;
    @(posedge clk);
    {wr, bwr, ld, push, pop, dinc} <= 6'h00;
    op <= CSR_OP_NONE;
    #1;
  endtask
  task wreg(input logic [7:0] ad, d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'h1;
    tick();
  endtask
  task bitw(input logic [7:0] ad, input logic [2:0] sl, input logic b1);
    @(posedge clk);
    addr <= ad;
    bsel <= sl;
    bval <= b1;
    bwr <= 1'h1;
    tick();
  endtask
  task look(input logic [7:0] ad, input logic [2:0] sl);
    @(posedge clk);
    addr <= ad;
    bsel <= sl;
    #1;
  endtask
  task strobe(input int k, input logic [7:0] d);
    @(posedge clk);
    push <= (k == 0);
    pop <= (k == 1);
    dinc <= (k == 2);
    ld <= (k == 3);
    lddata <= d;
    pbyte <= d;
    tick();
  endtask
  task alu(input csr_op_e o, input logic [7:0] xv);
    @(posedge clk);
    op <= o;
    opnd <= xv;
    tick();
  endtask
  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    {clk, rstn, wr, bwr, bval, ld, push, pop, dinc} = 9'h000;
    {addr, wdata, opnd, lddata, pbyte, bsel} = 43'h0;
    op = CSR_OP_NONE;
    seed = 32'h0000005C;
    n_errors = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    #1;
    chk("reset", {stk, pri}, 16'h0700);
    chk("reset", {sec, stat}, 16'h0000);
    chk("reset", dp16, 16'h0000);
    look(8'h85, 3'h0);
    chk("unmapped", {rdata, ramsel, hit}, 16'h0000);
    look(8'h10, 3'h0);
    chk("ram select", ramsel, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      got[i] = rnd();
      wreg(regs[i], got[i]);
      look(regs[i], 3'h0);
      chk("direct read", {rdata, 7'h00, hit}, {got[i], 8'h01});
    end
    chk("pointer", dp16, {got[2], got[1]});
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      wreg(8'hD0, {v[7:5], k[1:0], v[2:0]});
      chk("bank", bank, 16'(k * 8));
      chk("status", stat, {v[7:5], k[1:0], v[2:1], ^pri});
    end
    v = rnd();
    bitw(8'hE0, v[2:0], v[3]);
    look(8'hE0, v[2:0]);
    chk("bit", {pri[v[2:0]], brd}, {2{v[3]}});
    wreg(8'h82, 8'hFF);
    wreg(8'h83, 8'h00);
    bitw(8'h82, 3'h0, 1'h0);
    chk("bit refused", dp16, 16'h00FF);
    strobe(2, 8'h00);
    chk("pointer carry", dp16, 16'h0100);
    wreg(8'h81, 8'h07);
    chk("push address", stkw, 16'h0008);
    v = rnd();
    strobe(0, v);
    chk("push", {stk, top}, {8'h08, v});
    strobe(1, 8'h00);
    chk("pop", stk, 16'h0007);
    for (int i = 0; i < 50; i++) begin
      a = rnd();
      x = rnd();
      s = (i % 10 == 9) ? 8'h00 : rnd();
      c = rnd() > 8'h7F;
      strobe(3, a);
      chk("parity", stat[0], ^a);
      wreg(8'hF0, s);
      bitw(8'hD0, 3'h7, c);
      look(8'hD0, 3'h7);
      chk("carry bit", brd, c);
      e = want(ops[i % 5], a, x, s, c);
      keep = {stat[5:3], stat[1], 1'h0};
      alu(ops[i % 5], x);
      chk("arith", {sec, pri}, {e[18:11], e[7:0]});
      chk("flags", {stat[7:6], stat[2], stat[0]}, {e[10:8], ^e[7:0]});
      chk("user", {stat[5:3], stat[1], 1'h0}, keep);
    end
    // reset again in mid-run, then a first push right after release
    @(posedge clk);
    rstn <= 1'h0;
    @(posedge clk);
    rstn <= 1'h1;
    #1;
    chk("reset again", {stk, pri}, 16'h0700);
    chk("reset again", {sec, stat}, 16'h0000);
    chk("reset again", dp16, 16'h0000);
    strobe(0, 8'hA5);
    chk("push after reset", stk, 16'h0008);
    finish_test();
  end
endmodule
